// >>> logic/munch_pkg.sv
// constants shared by the munching squares demo and its tone generators
package munch_pkg;
	// system clock
	localparam longint CLK_HZ = 64'd10_000_000;
	localparam int CLK_MHZ = 10;
	// horizontal timing in pixel clocks
	localparam logic [9:0] H_VISIBLE = 10'h280;
	localparam logic [9:0] H_SYNC_START = 10'h290;
	localparam logic [9:0] H_SYNC_END = 10'h2F0;
	localparam logic [9:0] H_LAST = 10'h31F;
	// vertical timing in lines
	localparam logic [9:0] V_VISIBLE = 10'h1E0;
	localparam logic [9:0] V_SYNC_START = 10'h1EA;
	localparam logic [9:0] V_SYNC_END = 10'h1EC;
	localparam logic [9:0] V_LAST = 10'h20C;
	// persistence: the current frame plus this many older ones
	localparam int PERSIST_FRAMES = 14;
	// colour per age band, two bits each
	localparam logic [5:0] RGB_NEW = 6'h2B;
	localparam logic [5:0] RGB_YELLOW_HI = 6'h3C;
	localparam logic [5:0] RGB_YELLOW_MID = 6'h28;
	localparam logic [5:0] RGB_YELLOW_LO = 6'h14;
	localparam int AGE_HI_LAST = 4;
	localparam int AGE_MID_LAST = 9;
	// audio ensemble
	localparam int NUM_GEN = 8;
	localparam int PHASE_BITS = 24;
	localparam longint FREQ_LO_HZ = 64'd200;
	localparam longint FREQ_HI_HZ = 64'd1200;
	localparam logic [11:0] INC_LO = 12'((FREQ_LO_HZ << PHASE_BITS) / CLK_HZ);
	localparam logic [11:0] INC_SPAN = 12'(((FREQ_HI_HZ - FREQ_LO_HZ) << PHASE_BITS) / CLK_HZ);
	// one logistic iterate per this interval
	localparam int ITER_PERIOD_US = 10000;
	// r in unsigned Q2.14, x in Q0.16
	localparam logic [15:0] R_START = 16'h4400;
	localparam logic [15:0] R_FAST_END = 16'hC000;
	localparam logic [15:0] R_STEP_FAST = 16'h0008;
	localparam logic [15:0] R_STEP_SLOW = 16'h0002;
	localparam logic [15:0] X_SEED = 16'h8000;
	// periodic islands of the chaotic region and the generator count used there
	localparam logic [15:0] R_P6_LO = 16'hE829;
	localparam logic [15:0] R_P6_HI = 16'hE858;
	localparam logic [15:0] R_P5_LO = 16'hEF3F;
	localparam logic [15:0] R_P5_HI = 16'hEF6E;
	localparam logic [15:0] R_P3_LO = 16'hF505;
	localparam logic [15:0] R_P3_HI = 16'hF5DB;
	localparam logic [3:0] ACTIVE_ALL = 4'h8;
	localparam logic [3:0] ACTIVE_P6 = 4'h6;
	localparam logic [3:0] ACTIVE_P5 = 4'h5;
	localparam logic [3:0] ACTIVE_P3 = 4'h6;
	// bidirectional pin used for audio
	localparam int AUDIO_PIN = 7;
endpackage : munch_pkg

// >>> logic/square_gen.sv
// one square-wave tone generator built on a phase accumulator
module square_gen
	import munch_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// frequency load
	input wire logic load_i,
	input wire logic [11:0] inc_i,
	// tone
	output logic wave_o
);
	logic [11:0] inc;
	logic [PHASE_BITS-1:0] phase;

	// no phase reset on load, so tones stay continuous
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			inc <= 12'h000;
		end else if (load_i) begin
			inc <= inc_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			phase <= '0;
		end else begin
			phase <= phase + PHASE_BITS'(inc);
		end
	end

	assign wave_o = phase[PHASE_BITS-1];
endmodule : square_gen

// >>> logic/munch_demo.sv
// munching squares video with persistence and a logistic map sonification
// Notes on behaviour
// - nine-bit frame counter and row index; frame count wraps at 512 each frame end
// - each row lights one point at column frame XOR row
// - raster is 640 by 480; square rows past line 479 are unseen
// - pixel lit in any of 14 older frames; new blue-white, older yellow fading
// - video repeats once per full wrap of the frame counter
// - audio logic shares only clock and reset with video
// - iterate x as r times x times one minus x, fixed point
// - each iterate maps to about 200 to 1200 Hz, loaded into one of 8 tones
// - active tones are summed into the duty of a PWM on the audio pin
// - r sweeps 17/16 toward 4 in about two minutes, faster below 3
// - in periodic islands fewer tones are updated and mixed, a period multiple
// - demo held in reset while reset is asserted, runs when released
// - each colour component has a high and a low bit
module munch_demo
	import munch_pkg::*;
#(
	parameter int ITER_CYCLES = ITER_PERIOD_US * CLK_MHZ
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// video
	output logic [1:0] red_o,
	output logic [1:0] green_o,
	output logic [1:0] blue_o,
	output logic hsync_n_o,
	output logic vsync_n_o,
	// bidirectional pins
	output logic [7:0] bidir_out_o,
	output logic [7:0] bidir_oe_o
);
	localparam int ITER_W = $clog2(ITER_CYCLES);

	logic [9:0] h_cnt;
	logic [9:0] v_cnt;
	logic [8:0] frame;
	logic frame_end;
	logic visible;
	logic [PERSIST_FRAMES:0] hit;
	logic [5:0] next_rgb;

	assign frame_end = (h_cnt == H_LAST) && (v_cnt == V_LAST);
	assign visible = (h_cnt < H_VISIBLE) && (v_cnt < V_VISIBLE);

	// beam position; the single board clock is the pixel clock
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			h_cnt <= 10'h000;
			v_cnt <= 10'h000;
		end else if (h_cnt == H_LAST) begin
			h_cnt <= 10'h000;
			v_cnt <= (v_cnt == V_LAST) ? 10'h000 : v_cnt + 10'h001;
		end else begin
			h_cnt <= h_cnt + 10'h001;
		end
	end

	// pattern period is exactly one wrap of this counter
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			frame <= 9'h000;
		end else if (frame_end) begin
			frame <= frame + 9'h001;
		end
	end

	// the row index is the low nine bits of the line; rows past 479 never show
	always_comb begin
		logic [8:0] past_frame;
		past_frame = 9'h000;
		hit = '0;
		for (int k = 0; k <= PERSIST_FRAMES; k++) begin
			past_frame = frame - 9'(k);
			hit[k] = (h_cnt == {1'b0, past_frame ^ v_cnt[8:0]});
		end
	end

	// youngest hit wins; all compares are parallel, no frame buffer needed
	always_comb begin
		next_rgb = 6'h00;
		for (int k = PERSIST_FRAMES; k >= 1; k--) begin
			if (hit[k]) begin
				if (k <= AGE_HI_LAST) begin
					next_rgb = RGB_YELLOW_HI;
				end else if (k <= AGE_MID_LAST) begin
					next_rgb = RGB_YELLOW_MID;
				end else begin
					next_rgb = RGB_YELLOW_LO;
				end
			end
		end
		if (hit[0]) begin
			next_rgb = RGB_NEW;
		end
		if (!visible) begin
			next_rgb = 6'h00;
		end
	end

	// colour and sync registered together so they stay aligned
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			red_o <= 2'h0;
			green_o <= 2'h0;
			blue_o <= 2'h0;
			hsync_n_o <= 1'b1;
			vsync_n_o <= 1'b1;
		end else begin
			red_o <= next_rgb[5:4];
			green_o <= next_rgb[3:2];
			blue_o <= next_rgb[1:0];
			hsync_n_o <= !((h_cnt >= H_SYNC_START) && (h_cnt < H_SYNC_END));
			vsync_n_o <= !((v_cnt >= V_SYNC_START) && (v_cnt < V_SYNC_END));
		end
	end

	// audio: none of the audio logic below reads any video signal; only the assertions do
	logic [ITER_W-1:0] iter_cnt;
	logic iter_tick;
	logic [15:0] r_val;
	logic [15:0] x_val;
	logic [15:0] next_x;
	logic [15:0] next_r;
	logic [3:0] active_cnt;
	logic [3:0] next_active;
	logic [2:0] gen_sel;
	logic [NUM_GEN-1:0] gen_load;
	logic [11:0] gen_inc;
	logic [NUM_GEN-1:0] waves;
	logic [3:0] mix_sum;
	logic [2:0] pwm_cnt;

	assign iter_tick = (iter_cnt == ITER_W'(ITER_CYCLES - 1));

	always_ff @(posedge clk_sys_i) begin
		if (rst_i || iter_tick) begin
			iter_cnt <= '0;
		end else begin
			iter_cnt <= iter_cnt + ITER_W'(1);
		end
	end

	// x*(1-x) is at most a quarter, so r*p never overflows below r=4
	always_comb begin
		logic [31:0] p_full;
		logic [31:0] q_full;
		p_full = 32'(x_val) * 32'(16'hFFFF - x_val);
		q_full = 32'(r_val) * 32'(p_full[31:16]);
		next_x = q_full[29:14];
		if (next_x == 16'h0000) begin
			next_x = X_SEED;
		end
	end

	always_comb begin
		logic [16:0] r_sum;
		r_sum = {1'b0, r_val} + {1'b0, (r_val < R_FAST_END) ? R_STEP_FAST : R_STEP_SLOW};
		next_r = r_sum[16] ? R_START : r_sum[15:0];
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			r_val <= R_START;
			x_val <= X_SEED;
		end else if (iter_tick) begin
			r_val <= next_r;
			x_val <= next_x;
		end
	end

	// island counts are period multiples that fit within eight tones
	// decoded from the next r so count and round-robin switch on the same tick
	always_comb begin
		if ((next_r >= R_P3_LO) && (next_r <= R_P3_HI)) begin
			next_active = ACTIVE_P3;
		end else if ((next_r >= R_P5_LO) && (next_r <= R_P5_HI)) begin
			next_active = ACTIVE_P5;
		end else if ((next_r >= R_P6_LO) && (next_r <= R_P6_HI)) begin
			next_active = ACTIVE_P6;
		end else begin
			next_active = ACTIVE_ALL;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			active_cnt <= ACTIVE_ALL;
		end else if (iter_tick) begin
			active_cnt <= next_active;
		end
	end

	// round-robin over the active tones only; never points at an idle tone
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			gen_sel <= 3'h0;
		end else if (iter_tick) begin
			gen_sel <= ({1'b0, gen_sel} + 4'h1 >= next_active) ? 3'h0 : gen_sel + 3'h1;
		end
	end

	always_comb begin
		logic [27:0] span;
		span = 28'(x_val) * 28'(INC_SPAN);
		gen_inc = INC_LO + span[27:16];
		gen_load = '0;
		gen_load[gen_sel] = iter_tick;
	end

	for (genvar g = 0; g < NUM_GEN; g++) begin : gen_tones
		square_gen u_tone (
			.clk_sys_i(clk_sys_i),
			.rst_i(rst_i),
			.load_i(gen_load[g]),
			.inc_i(gen_inc),
			.wave_o(waves[g])
		);
	end

	always_comb begin
		mix_sum = 4'h0;
		for (int g = 0; g < NUM_GEN; g++) begin
			if (4'(g) < active_cnt) begin
				mix_sum = mix_sum + {3'h0, waves[g]};
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pwm_cnt <= 3'h0;
		end else begin
			pwm_cnt <= pwm_cnt + 3'h1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			bidir_out_o <= 8'h00;
			bidir_oe_o <= 8'h00;
		end else begin
			bidir_out_o <= 8'h00;
			bidir_out_o[AUDIO_PIN] <= (mix_sum > {1'b0, pwm_cnt});
			bidir_oe_o <= 8'h01 << AUDIO_PIN;
		end
	end

	sequence frame_end_s;
		frame_end ##1 (h_cnt == 10'h000) && (v_cnt == 10'h000);
	endsequence

	AST_FRAME_ADV: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		frame_end_s |-> frame == $past(frame, 1) + 9'h001) else $error("frame count did not advance");
	AST_HSYNC_POS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		$fell(hsync_n_o) |-> h_cnt == H_SYNC_START + 10'h001) else $error("hsync fell at wrong column");
	AST_VSYNC_POS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		$fell(vsync_n_o) |-> v_cnt == V_SYNC_START && h_cnt == 10'h001) else $error("vsync misplaced");
	AST_BLANK: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!visible |=> {red_o, green_o, blue_o} == 6'h00) else $error("colour outside visible area");
	AST_NEW_POINT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(visible && h_cnt == {1'b0, frame ^ v_cnt[8:0]}) |=> {red_o, green_o, blue_o} == RGB_NEW)
		else $error("current point not blue-white");
	AST_OLD_POINT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(visible && !hit[0] && h_cnt == {1'b0, (frame - 9'(PERSIST_FRAMES)) ^ v_cnt[8:0]}
			&& hit[PERSIST_FRAMES-1:1] == '0) |=> {red_o, green_o, blue_o} == RGB_YELLOW_LO)
		else $error("oldest point colour wrong");
	AST_R_RANGE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		iter_tick |=> r_val >= R_START && (r_val - $past(r_val) <= R_STEP_FAST || r_val == R_START))
		else $error("r left its sweep");
	AST_ISLAND: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(r_val >= R_P5_LO && r_val <= R_P5_HI) |-> active_cnt == ACTIVE_P5
			&& {1'b0, gen_sel} < ACTIVE_P5)
		else $error("period-5 island uses wrong tone count");
	AST_LOAD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		iter_tick |-> $onehot(gen_load) && gen_inc >= INC_LO) else $error("tone load malformed");
	AST_PWM_LOW: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(mix_sum == 4'h0)[*2] |=> !bidir_out_o[AUDIO_PIN]) else $error("pwm high with silent mix");
endmodule : munch_demo

// >>> bench/monitor_model.sv
// board model: display line timing monitor and pwm audio filter input
module monitor_model
	import munch_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// video and audio seen by the board
	input wire logic hsync_n_i,
	input wire logic audio_i,
	// measurements
	output int line_len_o,
	output int sync_len_o,
	output int audio_high_o,
	output int audio_total_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int since_fall;
	int low_run;
	logic hsync_q;

	// line period taken between falling sync edges, apart from the bench model
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			since_fall <= 0;
			low_run <= 0;
			hsync_q <= 1'b1;
			line_len_o <= 0;
			sync_len_o <= 0;
		end else begin
			hsync_q <= hsync_n_i;
			since_fall <= since_fall + 1;
			if (hsync_q && !hsync_n_i) begin
				line_len_o <= since_fall;
				since_fall <= 1;
			end
			if (!hsync_n_i) begin
				low_run <= low_run + 1;
			end else if (!hsync_q) begin
				sync_len_o <= low_run;
				low_run <= 0;
			end
		end
	end

	// the filter only integrates: a stuck pin shows as all high or all low
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			audio_high_o <= 0;
			audio_total_o <= 0;
		end else begin
			audio_total_o <= audio_total_o + 1;
			audio_high_o <= audio_high_o + (audio_i ? 1 : 0);
		end
	end
endmodule : monitor_model

// >>> bench/testbench.sv
// self-checking bench for the munching squares demo
module testbench
	import munch_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int ITER = 4;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [1:0] red_o;
	logic [1:0] green_o;
	logic [1:0] blue_o;
	logic hsync_n_o;
	logic vsync_n_o;
	logic [7:0] bidir_out_o;
	logic [7:0] bidir_oe_o;
	logic audio_pin;
	logic [31:0] seed = 32'hec0c_d411;
	int mismatches = 0;
	int checks_done = 0;
	int h, v, fr, line_len, sync_len, a_hi, a_tot;
	bit running = 0;
	bit in_rst = 0;
	int a_cnt, a_r, a_x, a_sel, a_act, pwm, mix;
	int inc_q[NUM_GEN];
	int ph_q[NUM_GEN];
	longint prod;
	bit exp_audio = 0;

	always #50 clk_sys_i = ~clk_sys_i;

	munch_demo #(.ITER_CYCLES(ITER)) dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.red_o(red_o), .green_o(green_o), .blue_o(blue_o), .hsync_n_o(hsync_n_o),
		.vsync_n_o(vsync_n_o), .bidir_out_o(bidir_out_o), .bidir_oe_o(bidir_oe_o));

	// released pin is pulled low by the filter board
	assign audio_pin = bidir_oe_o[7] ? bidir_out_o[7] : 1'b0;

	monitor_model board_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsync_n_i(hsync_n_o),
		.audio_i(audio_pin), .line_len_o(line_len), .sync_len_o(sync_len),
		.audio_high_o(a_hi), .audio_total_o(a_tot));

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xorshift

	// youngest frame wins, so search from the current frame backwards
	function automatic logic [5:0] exp_rgb(input int hh, input int vv, input int ff);
		int col;
		if (hh >= 640 || vv >= 480) return 6'h00;
		for (int k = 0; k <= PERSIST_FRAMES; k++) begin
			col = ((ff - k) & 511) ^ (vv & 511);
			if (hh == col) begin
				if (k == 0) return RGB_NEW;
				if (k <= AGE_HI_LAST) return RGB_YELLOW_HI;
				if (k <= AGE_MID_LAST) return RGB_YELLOW_MID;
				return RGB_YELLOW_LO;
			end
		end
		return 6'h00;
	endfunction : exp_rgb

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report();
		$display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report

	// beam position of the pixel shown after this edge
	always @(posedge clk_sys_i) begin
		in_rst = rst_i;
		if (rst_i) begin
			running = 0;
			h = 0;
			v = 0;
			fr = 0;
		end else if (!running) begin
			running = 1;
		end else begin
			h++;
			if (h == 800) begin
				h = 0;
				v++;
				if (v == 525) begin
					v = 0;
					fr = (fr + 1) % 512;
				end
			end
		end
	end

	function automatic int island(input int rr);
		if (rr >= R_P3_LO && rr <= R_P3_HI) return ACTIVE_P3;
		if (rr >= R_P5_LO && rr <= R_P5_HI) return ACTIVE_P5;
		if (rr >= R_P6_LO && rr <= R_P6_HI) return ACTIVE_P6;
		return ACTIVE_ALL;
	endfunction : island

	// audio model: one iterate every ITER clocks, tones summed against an 8-step pwm
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			a_cnt = 0;
			a_r = R_START;
			a_x = X_SEED;
			a_sel = 0;
			a_act = ACTIVE_ALL;
			pwm = 0;
			for (int g = 0; g < NUM_GEN; g++) begin
				inc_q[g] = 0;
				ph_q[g] = 0;
			end
		end else begin
			mix = 0;
			for (int g = 0; g < a_act; g++) begin
				mix += ph_q[g] >> (PHASE_BITS - 1);
			end
			exp_audio = (mix > pwm);
			pwm = (pwm + 1) % 8;
			for (int g = 0; g < NUM_GEN; g++) begin
				ph_q[g] = (ph_q[g] + inc_q[g]) % (1 << PHASE_BITS);
			end
			if (a_cnt == ITER - 1) begin
				a_cnt = 0;
				inc_q[a_sel] = INC_LO + ((a_x * INC_SPAN) >> 16);
				prod = longint'(a_x) * (65535 - a_x);
				prod = ((longint'(a_r) * (prod >> 16)) >> 14) % 65536;
				a_x = (prod == 0) ? int'(X_SEED) : int'(prod);
				a_r = a_r + ((a_r < R_FAST_END) ? R_STEP_FAST : R_STEP_SLOW);
				if (a_r > 65535) a_r = R_START;
				a_act = island(a_r);
				a_sel = (a_sel + 1 >= a_act) ? 0 : a_sel + 1;
			end else begin
				a_cnt++;
			end
		end
	end

	always @(negedge clk_sys_i) begin
		if (in_rst) begin
			check({10'h000, red_o, green_o, blue_o}, 16'h0000);
			check({14'h0000, hsync_n_o, vsync_n_o}, 16'h0003);
			check({bidir_oe_o, bidir_out_o}, 16'h0000);
		end else if (running) begin
			check({10'h000, red_o, green_o, blue_o}, {10'h000, exp_rgb(h, v, fr)});
			check({14'h0000, hsync_n_o, vsync_n_o},
				{14'h0000, !(h >= 656 && h <= 751), !(v >= 490 && v <= 491)});
			check({bidir_oe_o, 1'b0, bidir_out_o[6:0]}, 16'h8000);
			check({15'h0000, bidir_out_o[7]}, {15'h0000, exp_audio});
		end
	end

	initial begin
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		repeat (40000) @(posedge clk_sys_i);
		seed = xorshift(seed);
		repeat (seed[9:0]) @(posedge clk_sys_i);
		// a second reset in mid-line must restart the beam at the origin
		rst_i <= 1'b1;
		seed = xorshift(seed);
		repeat (1 + seed[2:0]) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		repeat (45000) @(posedge clk_sys_i);
		check(16'(line_len), 16'h0320);
		check(16'(sync_len), 16'h0060);
		check({15'h0000, a_hi != 0 && a_hi != a_tot}, 16'h0001);
		final_report();
	end

	// the run needs at most about 86000 cycles
	initial begin
		#(100 * 95000);
		mismatches++;
		final_report();
	end
endmodule : testbench
